//--- pkg/timer_event_counter_map.svh
`ifndef TIMER_EVENT_COUNTER_MAP_SVH
`define TIMER_EVENT_COUNTER_MAP_SVH
`define TMC_OFFSET      12'hfa0
`define TMC_RESET       8'h00
`define TMC_ENABLE_BIT  2
`define TMC_START_BIT   3
`define TMC_SEL_LSB     4
`define TMC_SEL_MSB     6
`define SEL_EXT_RISE    3'h0
`define SEL_EXT_FALL    3'h1
`define SEL_DIV10       3'h4
`define SEL_DIV8        3'h5
`define SEL_DIV6        3'h6
`define SEL_DIV4        3'h7
`define TAP_DIV10       9
`define TAP_DIV8        7
`define TAP_DIV6        5
`define TAP_DIV4        3
`define PRESCALE_RESET  10'h000
`define COUNT_RESET     8'h00
`endif

//--- pkg/timer_event_counter_pkg.sv
package timer_event_counter_pkg;
  typedef struct packed {
    logic [2:0] pulse_select;
    logic       start_bit;
    logic       count_enable_bit;
  } mode_fields_s;

  typedef struct packed {
    logic       write_all;
    logic       write_start;
    logic [7:0] data;
  } mode_write_s;
endpackage : timer_event_counter_pkg

//--- design/timer_event_counter.sv
`include "timer_event_counter_map.svh"
module timer_event_counter #(
  parameter int PRESCALE_WIDTH = 10
) (
  input  wire logic       i_mclk,
  input  wire logic       i_resetn,
  input  wire logic       i_ce,
  input  wire logic       i_mode_write,
  input  wire logic       i_start_write,
  input  wire logic [7:0] i_mode_wdata,
  input  wire logic       i_modulo_write,
  input  wire logic [7:0] i_modulo_wdata,
  input  wire logic       i_oe_write,
  input  wire logic       i_oe_wdata,
  input  wire logic       i_flag_set,
  input  wire logic       i_flag_clear,
  input  wire logic       i_event_input_pin,
  output logic [7:0]      o_timer_mode_control,
  output logic [7:0]      o_count_register,
  output logic [7:0]      o_modulo_value_register,
  output logic            o_output_enable_flag,
  output logic            o_timer_interrupt_flag,
  output logic            o_event_input_level,
  output logic            o_timer_output_pin,
  output logic            o_shift_clock
);
  logic                      rst_meta;
  logic                      rst_n;
  timer_event_counter_pkg::mode_fields_s mode;
  timer_event_counter_pkg::mode_write_s  wr;
  logic [7:0]                count_register;
  logic [7:0]                modulo_value_register;
  logic                      output_enable_flag;
  logic                      timer_interrupt_flag;
  logic                      timer_output_flipflop;
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] prescale_prev;
  logic [2:0]                ev_sync;
  logic                      ev_level;
  logic                      ev_level_prev;
  logic                      start_req;
  logic                      tap_pulse;
  logic                      count_pulse;
  logic                      match;
  logic                      period_end;
  logic [7:0]                next_count;
  logic [2:0]                sel;

  // Reset is released through two flops so every process sees a clean deassertion.
  always_ff @(posedge i_mclk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Write requests grouped; the start-only path takes priority over nothing, both may merge.
  assign wr        = '{write_all: i_mode_write, write_start: i_start_write, data: i_mode_wdata};
  assign start_req = (wr.write_all && wr.data[`TMC_START_BIT]) ||
                     (wr.write_start && wr.data[`TMC_START_BIT]);
  assign sel       = mode.pulse_select;

  // Prescaler taps give one-cycle pulses on the falling edge of each divided clock bit.
  assign tap_pulse = (sel == `SEL_DIV10) ? (prescale_prev[`TAP_DIV10] && !prescale[`TAP_DIV10]) :
                     (sel == `SEL_DIV8)  ? (prescale_prev[`TAP_DIV8]  && !prescale[`TAP_DIV8])  :
                     (sel == `SEL_DIV6)  ? (prescale_prev[`TAP_DIV6]  && !prescale[`TAP_DIV6])  :
                     (sel == `SEL_DIV4)  ? (prescale_prev[`TAP_DIV4]  && !prescale[`TAP_DIV4])  :
                     (sel == `SEL_EXT_RISE) ? (ev_level && !ev_level_prev) :
                     (sel == `SEL_EXT_FALL) ? (!ev_level && ev_level_prev) :
                     1'b0;

  // Pulses are gated by the enable bit; a start write wins over a coincident pulse.
  assign count_pulse = tap_pulse && mode.count_enable_bit && !start_req;
  assign match       = (count_register == modulo_value_register);
  assign period_end  = count_pulse && match;
  assign next_count  = period_end ? `COUNT_RESET : 8'(count_register + 8'h01);

  // Free-running prescaler; it is not cleared by start, so the first period may be short.
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale      <= `PRESCALE_RESET;
      prescale_prev <= `PRESCALE_RESET;
    end
    else if (i_ce)
    begin
      prescale      <= PRESCALE_WIDTH'(prescale + 1'b1);
      prescale_prev <= prescale;
    end
  end

  // Event pin passes three flops; a level change counts once the last two agree.
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ev_sync       <= 3'h0;
      ev_level      <= 1'b0;
      ev_level_prev <= 1'b0;
    end
    else if (i_ce)
    begin
      ev_sync       <= {ev_sync[1:0], i_event_input_pin};
      if (ev_sync[1] == ev_sync[2])
      begin
        ev_level <= ev_sync[2];
      end
      ev_level_prev <= ev_level;
    end
  end

  // Mode register: whole-byte write or start-only write; start reads back as zero one cycle after it is taken.
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode <= 5'(`TMC_RESET);
    end
    else if (i_ce)
    begin
      if (wr.write_all)
      begin
        mode.pulse_select     <= wr.data[`TMC_SEL_MSB:`TMC_SEL_LSB];
        mode.count_enable_bit <= wr.data[`TMC_ENABLE_BIT];
      end
      // Start shows for one cycle after it is taken, then reads back as zero by itself.
      mode.start_bit <= start_req;
    end
  end

  // Counter, modulo and output flop; modulo write works in any mode.
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_register        <= `COUNT_RESET;
      modulo_value_register <= `COUNT_RESET;
      timer_output_flipflop <= 1'b0;
      output_enable_flag    <= 1'b0;
    end
    else if (i_ce)
    begin
      if (i_modulo_write)
      begin
        modulo_value_register <= i_modulo_wdata;
      end
      if (i_oe_write)
      begin
        output_enable_flag <= i_oe_wdata;
      end
      if (start_req)
      begin
        count_register        <= `COUNT_RESET;
        timer_output_flipflop <= 1'b0;
      end
      else if (count_pulse)
      begin
        count_register <= next_count;
        if (match)
        begin
          timer_output_flipflop <= !timer_output_flipflop;
        end
      end
    end
  end

  // Interrupt flag: a period end or software set wins over a software clear; a start write blocks any period end in its cycle.
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_interrupt_flag <= 1'b0;
    end
    else if (i_ce)
    begin
      if (period_end || i_flag_set)
      begin
        timer_interrupt_flag <= 1'b1;
      end
      else if (start_req || i_flag_clear)
      begin
        timer_interrupt_flag <= 1'b0;
      end
    end
  end

  // Shift clock is registered so the serial block sees a glitch-free pulse.
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_shift_clock <= 1'b0;
    end
    else if (i_ce)
    begin
      o_shift_clock <= period_end;
    end
  end

  // Register views and pin drive; all readable regardless of count enable.
  assign o_timer_mode_control    = {1'b0, mode.pulse_select, mode.start_bit,
                                    mode.count_enable_bit, 2'h0};
  assign o_count_register        = count_register;
  assign o_modulo_value_register = modulo_value_register;
  assign o_output_enable_flag    = output_enable_flag;
  assign o_timer_interrupt_flag  = timer_interrupt_flag;
  assign o_event_input_level     = ev_level;
  assign o_timer_output_pin      = output_enable_flag && timer_output_flipflop;
endmodule : timer_event_counter

//--- tb/event_source.sv
module event_source (
  input  wire logic       i_mclk,
  input  wire logic       i_go,
  input  wire logic [7:0] i_pulses,
  output logic            o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left = 8'h00;
  logic [3:0] phase = 4'h0;
  // Pulses run eight clocks low, then eight high, slow enough for any pin synchroniser.
  always @(posedge i_mclk)
  begin
    if (i_go)
      left <= i_pulses;
    else if (left != 8'h00)
    begin
      phase <= phase + 4'h1;
      if (phase == 4'hf)
        left <= left - 8'h01;
    end
  end
  assign o_pin = (left != 8'h00) && phase[3];
endmodule : event_source

//--- tb/timer_event_counter_checker.sv
module timer_event_counter_checker (
  input wire logic       i_mclk, i_resetn, i_ce, i_mode_write, i_start_write, i_flag_set,
  input wire logic [7:0] i_mode_wdata, o_timer_mode_control, o_count_register,
  input wire logic       o_output_enable_flag, o_timer_interrupt_flag, o_timer_output_pin,
  input wire logic       o_shift_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // A period end is a flag rise that no software set explains.
  sequence wrap_s;
    $rose(o_timer_interrupt_flag) && !$past(i_flag_set);
  endsequence
  a_reset_clears: assert property (disable iff (1'b0) !i_resetn |->
    o_timer_mode_control == 8'h00 && !o_output_enable_flag && !o_timer_output_pin)
    else $error("state not cleared in reset");
  a_pin_gated: assert property (o_timer_output_pin |-> o_output_enable_flag)
    else $error("pin driven while disabled");
  a_start_self_clear: assert property (o_timer_mode_control[3] |=> !o_timer_mode_control[3])
    else $error("start bit stuck");
  a_start_clears: assert property (i_ce && (i_mode_write || i_start_write) &&
    i_mode_wdata[3] && !i_flag_set |=> o_count_register == 8'h00 && !o_timer_interrupt_flag)
    else $error("start left count or flag");
  a_halt_holds: assert property (!o_timer_mode_control[2] && !i_mode_write &&
    !i_start_write |=> $stable(o_count_register)) else $error("count moved while halted");
  a_wrap_zero: assert property (wrap_s |-> o_count_register == 8'h00)
    else $error("count not zero at period end");
  a_wrap_toggle: assert property (wrap_s ##0 o_output_enable_flag &&
    $past(o_output_enable_flag) |-> o_timer_output_pin != $past(o_timer_output_pin))
    else $error("output did not toggle");
  a_shift_follows: assert property (wrap_s |-> ##[0:1] o_shift_clock)
    else $error("no shift clock at period end");
  a_shift_single: assert property (o_shift_clock |=> !o_shift_clock)
    else $error("shift clock too long");
endmodule : timer_event_counter_checker

bind timer_event_counter timer_event_counter_checker u_checker (.i_mclk, .i_resetn, .i_ce,
  .i_mode_write, .i_start_write, .i_flag_set, .i_mode_wdata, .o_timer_mode_control,
  .o_count_register, .o_output_enable_flag, .o_timer_interrupt_flag, .o_timer_output_pin,
  .o_shift_clock);

//--- tb/timer_event_counter_test.sv
module timer_event_counter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 0, i_resetn = 1, i_mode_write = 0, i_start_write = 0, i_modulo_write = 0;
  logic i_oe_write = 0, i_oe_wdata = 0, i_flag_set = 0, i_flag_clear = 0, go = 0, pin;
  logic [7:0] i_mode_wdata = 8'h00, i_modulo_wdata = 8'h00, pulses = 8'h00;
  logic [7:0] o_timer_mode_control, o_count_register, o_modulo_value_register;
  logic o_output_enable_flag, o_timer_interrupt_flag, o_timer_output_pin, o_event_input_level;
  int bad_count = 0, n_compared = 0;
  always #10 i_mclk = ~i_mclk;
  timer_event_counter u_dut (.i_mclk, .i_resetn, .i_ce(1'b1), .i_mode_write, .i_start_write,
    .i_mode_wdata, .i_modulo_write, .i_modulo_wdata, .i_oe_write, .i_oe_wdata, .i_flag_set,
    .i_flag_clear, .i_event_input_pin(pin), .o_timer_mode_control, .o_count_register,
    .o_modulo_value_register, .o_output_enable_flag, .o_timer_interrupt_flag,
    .o_event_input_level, .o_timer_output_pin, .o_shift_clock());
  event_source u_src (.i_mclk, .i_go(go), .i_pulses(pulses), .o_pin(pin));
  // Inputs always move one nanosecond after an edge, never on it.
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : step
  task automatic strobe(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask : strobe
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  // Modulo is loaded before the mode byte, the order software must keep.
  task automatic set_mode(input logic [7:0] m, input logic [7:0] mod);
    i_modulo_wdata = mod;
    strobe(i_modulo_write);
    i_mode_wdata = m;
    strobe(i_mode_write);
  endtask : set_mode
  // Bounded wait; a hang shows up as a wrong cycle count.
  task automatic wait_flag(output int n);
    n = 0;
    while (o_timer_interrupt_flag !== 1'b1 && n < 3000)
    begin
      step(1);
      n++;
    end
  endtask : wait_flag
  // Each tap is timed over a full period; the first period may be short.
  task automatic test_prescaled;
    int n;
    i_oe_wdata = 1'b1;
    strobe(i_oe_write);
    for (int i = 0; i < 4; i++)
    begin
      set_mode({1'b0, 3'h4 + 3'(i), 4'hc}, 8'h01);
      check(o_count_register, 8'h00);
      step(1);
      check(o_timer_mode_control[3], 1'b0);
      wait_flag(n);
      strobe(i_flag_clear);
      wait_flag(n);
      check(16'(n), (16'h2 << (10 - 2 * i)) - 16'h1);
    end
    // A third period leaves the flop high, so both the gate and the start clear can show.
    strobe(i_flag_clear);
    wait_flag(n);
    check(o_timer_output_pin, 1'b1);
    i_oe_wdata = 1'b0;
    strobe(i_oe_write);
    check(o_timer_output_pin, 1'b0);
    step(1);
    i_oe_wdata = 1'b1;
    strobe(i_oe_write);
    check(o_timer_output_pin, 1'b1);
    i_mode_wdata = 8'h08;
    strobe(i_start_write);
    check(o_timer_output_pin, 1'b0);
    $display("prescaled taps done");
  endtask : test_prescaled
  task automatic send(input logic [7:0] k);
    pulses = k;
    strobe(go);
    step(16 * k + 8);
  endtask : send
  // Event edges, halting, lone start write and flag access while halted.
  task automatic test_events;
    set_mode(8'h0c, 8'h05);
    send(8'h04);
    check({o_timer_interrupt_flag, o_count_register}, 9'h004);
    send(8'h02);
    check({o_timer_interrupt_flag, o_count_register}, 9'h100);
    strobe(i_flag_clear);
    set_mode(8'h14, 8'h05);
    send(8'h02);
    check(o_count_register, 8'h02);
    set_mode(8'h10, 8'h05);
    send(8'h02);
    check(o_count_register, 8'h02);
    // One pulse while halted: the filtered pin level is still readable mid-pulse.
    pulses = 8'h01;
    strobe(go);
    step(13);
    check(o_event_input_level, 1'b1);
    step(11);
    check(o_count_register, 8'h02);
    i_mode_wdata = 8'hff;
    strobe(i_start_write);
    step(1);
    check(o_timer_mode_control, 8'h10);
    check(o_count_register, 8'h00);
    strobe(i_flag_set);
    check(o_timer_interrupt_flag, 1'b1);
    check(o_modulo_value_register, 8'h05);
    $display("event counting done");
  endtask : test_events
  initial
  begin
    // Reset falls just after time zero so the asynchronous clear sees a real edge.
    #1;
    i_resetn = 1'b0;
    step(8);
    i_resetn = 1'b1;
    step(3);
    check(o_timer_mode_control, 8'h00);
    check({o_output_enable_flag, o_timer_output_pin}, 2'b00);
    test_prescaled;
    test_events;
    stop_test;
  end
  // The run needs under 6000 clocks, so 40000 leaves ample margin.
  initial
  begin
    #800000;
    bad_count++;
    stop_test;
  end
endmodule : timer_event_counter_test
